/* verilog/pmg_top.sv */
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - Drive sixteen bit program memory address.
// RULE_02 - Write strobe low only during writes.
// RULE_03 - Read strobe low only during reads.
// RULE_04 - Chip enable asserted unless suspended.
// RULE_05 - Chip enable held high during reset.
// RULE_06 - Strap pull-up on while reset active.
// RULE_07 - Pull-up released few cycles after reset.
// RULE_08 - Sample strap once at reset release.
// RULE_09 - Strap value readable in input status.
// RULE_10 - Strap pin becomes general pin afterwards.
// RULE_11 - Low strap selects external program memory.
// RULE_12 - High or floating strap selects ROM.
// RULE_13 - Pins 1-5,7 support edge interrupts.
// RULE_14 - Pins 8-15 are plain input/output.
// RULE_15 - Latched source holds until next reset.
module pmg_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_chip_rst_n,
  input wire logic i_suspend,
  input wire pmg_pkg::pmg_reg_req_t i_reg_req,
  output logic [pmg_pkg::REG_DW-1:0] o_reg_rdata,
  output logic o_irq,
  input wire pmg_pkg::pmg_mem_req_t i_mem_req,
  output logic o_mem_busy,
  output pmg_pkg::pmg_mem_rsp_t o_mem_rsp,
  output pmg_pkg::pmg_mem_pins_t o_prog_mem,
  output logic [pmg_pkg::PM_DATA_W-1:0] o_prog_mem_data,
  output logic [pmg_pkg::PM_DATA_W-1:0] o_prog_mem_data_oe,
  input wire logic [pmg_pkg::PM_DATA_W-1:0] i_prog_mem_data,
  output logic o_mem_data_pullup_en,
  output logic o_internal_code_select,
  input wire logic [pmg_pkg::GPIO_W-1:0] i_gpio,
  output logic [pmg_pkg::GPIO_W-1:0] o_gpio_out,
  output logic [pmg_pkg::GPIO_W-1:0] o_gpio_oe,
  output logic o_strap_pullup_en,
  output logic o_serial_rxd
);

  import pmg_pkg::*;

  function automatic logic reg_hit(input logic [REG_AW-1:0] addr, input logic [REG_AW-1:0] off);
    return addr == off;
  endfunction

  // Pin synchronisers.
  logic chip_rst_n_s;
  logic [GPIO_W-1:0] gpio_s;
  logic [PM_DATA_W-1:0] mem_data_s;

  pmg_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_chip_rst_n),
    .o_q(chip_rst_n_s)
  );

  pmg_sync #(.WIDTH(GPIO_W), .RST_VAL(REG_RST_VAL)) u_gpio_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_gpio),
    .o_q(gpio_s)
  );

  // Read data also crosses two stages; the strobe is long enough to cover the lag.
  pmg_sync #(.WIDTH(PM_DATA_W), .RST_VAL(DATA_OE_NONE)) u_data_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_prog_mem_data),
    .o_q(mem_data_s)
  );

  // Chip reset tracking, strap capture and pull-up release.
  logic chip_rst_prev_q;
  logic code_sel_q;
  logic pullup_q;
  logic [CNT_W-1:0] pu_cnt_q;
  wire logic chip_rst_act = ~chip_rst_n_s;
  wire logic chip_rst_rise = chip_rst_n_s & ~chip_rst_prev_q;
  wire logic blk_rst = i_srst | chip_rst_act;

  // The strap is sampled only on the release edge, so later pin activity never moves it.
  wire logic code_sel_d = chip_rst_rise ? gpio_s[STRAP_PIN] : code_sel_q;  // see RULE_08, see RULE_15
  wire logic pu_done = pu_cnt_q == PULLUP_LAST;
  wire logic pullup_d = chip_rst_act ? 1'b1 : (pu_done ? 1'b0 : pullup_q);  // see RULE_06, see RULE_07
  wire logic [CNT_W-1:0] pu_cnt_d = (chip_rst_act | ~pullup_q) ? CNT_ZERO : pu_cnt_q + CNT_ONE;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chip_rst_prev_q <= 1'b0;
      code_sel_q <= 1'b1;
      pullup_q <= 1'b1;
      pu_cnt_q <= CNT_ZERO;
    end else begin
      chip_rst_prev_q <= chip_rst_n_s;
      code_sel_q <= code_sel_d;
      pullup_q <= pullup_d;
      pu_cnt_q <= pu_cnt_d;
    end
  end

  // External program memory port.
  pmg_mem_state_t state_q;
  pmg_mem_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic is_wr_q;
  logic is_wr_d;
  logic [PM_ADDR_W-1:0] addr_q;
  logic [PM_ADDR_W-1:0] addr_d;
  logic wr_n_q;
  logic wr_n_d;
  logic rd_n_q;
  logic rd_n_d;
  logic ce_n_q;
  logic [PM_DATA_W-1:0] dout_q;
  logic [PM_DATA_W-1:0] dout_d;
  logic [PM_DATA_W-1:0] doe_q;
  logic [PM_DATA_W-1:0] doe_d;
  logic busy_q;
  pmg_mem_rsp_t rsp_q;
  pmg_mem_rsp_t rsp_d;
  logic md_pu_q;

  // Fetches are refused while running from ROM, in suspend or in reset.
  wire logic mem_take = (state_q == MEM_IDLE) & ~code_sel_q & ~i_suspend & (i_mem_req.rd | i_mem_req.wr);  // see RULE_11, see RULE_12
  wire logic strobe_end = cnt_q == STROBE_LAST;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    is_wr_d = is_wr_q;
    addr_d = addr_q;
    wr_n_d = wr_n_q;
    rd_n_d = rd_n_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rsp_d = rsp_q;
    rsp_d.done = 1'b0;
    unique case (state_q)
      MEM_IDLE: begin
        if (mem_take) begin
          state_d = MEM_STROBE;
          cnt_d = CNT_ZERO;
          is_wr_d = i_mem_req.wr;
          addr_d = i_mem_req.addr;  // see RULE_01
          wr_n_d = ~i_mem_req.wr;  // see RULE_02
          rd_n_d = i_mem_req.wr;  // see RULE_03
          dout_d = i_mem_req.wdata;
          doe_d = i_mem_req.wr ? DATA_OE_ALL : DATA_OE_NONE;
        end
      end
      MEM_STROBE: begin
        cnt_d = cnt_q + CNT_ONE;
        if (strobe_end) begin
          state_d = MEM_RECOVER;
          wr_n_d = 1'b1;  // see RULE_02
          rd_n_d = 1'b1;  // see RULE_03
          rsp_d.done = 1'b1;
          if (!is_wr_q) begin
            rsp_d.rdata = mem_data_s;
          end
        end
      end
      MEM_RECOVER: begin
        // Write data is held one cycle past the strobe for hold time.
        state_d = MEM_IDLE;
        doe_d = DATA_OE_NONE;
      end
      default: begin
        state_d = MEM_IDLE;
        wr_n_d = 1'b1;
        rd_n_d = 1'b1;
        doe_d = DATA_OE_NONE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      state_q <= MEM_IDLE;
      cnt_q <= CNT_ZERO;
      is_wr_q <= 1'b0;
      addr_q <= '0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      ce_n_q <= 1'b1;  // see RULE_05
      dout_q <= DATA_OE_NONE;
      doe_q <= DATA_OE_NONE;
      busy_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      is_wr_q <= is_wr_d;
      addr_q <= addr_d;
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      ce_n_q <= i_suspend;  // see RULE_04
      dout_q <= dout_d;
      doe_q <= doe_d;
      busy_q <= state_d != MEM_IDLE;
      rsp_q <= rsp_d;
    end
  end

  // Data bus keepers are on only while code runs from ROM.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      md_pu_q <= 1'b1;
    end else begin
      md_pu_q <= code_sel_q;
    end
  end

  // General pins and registers.
  logic [GPIO_W-1:0] dir_q;
  logic [GPIO_W-1:0] out_q;
  logic [GPIO_W-1:0] irq_en_q;
  logic [GPIO_W-1:0] edge_q;
  logic [GPIO_W-1:0] mask_q;
  logic [GPIO_W-1:0] stat_q;
  logic [REG_DW-1:0] rdata_q;
  logic irq_q;
  logic [GPIO_W-1:0] gpio_out_q;
  logic [GPIO_W-1:0] gpio_oe_q;
  logic rxd_q;
  logic [GPIO_W-1:0] pin_event;

  wire logic wr_dir = i_reg_req.wr & reg_hit(i_reg_req.addr, REG_DIR_OFF);
  wire logic wr_out = i_reg_req.wr & reg_hit(i_reg_req.addr, REG_OUT_OFF);
  wire logic wr_irq_en = i_reg_req.wr & reg_hit(i_reg_req.addr, REG_IRQ_EN_OFF);
  wire logic wr_edge = i_reg_req.wr & reg_hit(i_reg_req.addr, REG_EDGE_OFF);
  wire logic wr_mask = i_reg_req.wr & reg_hit(i_reg_req.addr, REG_MASK_OFF);
  wire logic rd_stat = i_reg_req.rd & reg_hit(i_reg_req.addr, REG_STAT_OFF);

  pmg_edge_det #(.WIDTH(GPIO_W)) u_edge (
    .i_clk(i_clk),
    .i_srst(blk_rst),
    .i_level(gpio_s),
    .i_rise_sel(edge_q),
    .i_en(irq_en_q),
    .o_event(pin_event)
  );

  // Bit 0 carries the latched boot source beside the pin levels.
  wire logic [REG_DW-1:0] in_status = (gpio_s & PIN_VALID_MASK) | (ROM_SEL_MASK & {GPIO_W{code_sel_q}});  // see RULE_09
  // A new event in the clearing read's cycle survives the clear.
  wire logic [GPIO_W-1:0] stat_clr = rd_stat ? stat_q : REG_RST_VAL;
  wire logic [GPIO_W-1:0] stat_d = (stat_q & ~stat_clr) | (pin_event & IRQ_CAP_MASK);  // see RULE_13, see RULE_14
  wire logic [GPIO_W-1:0] mask_d = wr_mask ? (i_reg_req.wdata & IRQ_CAP_MASK) : mask_q;
  wire logic [REG_DW-1:0] rd_mux =
    reg_hit(i_reg_req.addr, REG_DIR_OFF) ? dir_q :
    reg_hit(i_reg_req.addr, REG_OUT_OFF) ? out_q :
    reg_hit(i_reg_req.addr, REG_IN_OFF) ? in_status :
    reg_hit(i_reg_req.addr, REG_IRQ_EN_OFF) ? irq_en_q :
    reg_hit(i_reg_req.addr, REG_EDGE_OFF) ? edge_q :
    reg_hit(i_reg_req.addr, REG_STAT_OFF) ? stat_q :
    reg_hit(i_reg_req.addr, REG_MASK_OFF) ? mask_q : REG_RST_VAL;
  // The strap pin may not be driven while its pull-up is still deciding the boot source.
  wire logic [GPIO_W-1:0] oe_d = dir_q & ~(pullup_q ? STRAP_MASK : REG_RST_VAL);  // see RULE_10

  always_ff @(posedge i_clk) begin
    if (blk_rst) begin
      dir_q <= REG_RST_VAL;
      out_q <= REG_RST_VAL;
      irq_en_q <= REG_RST_VAL;
      edge_q <= REG_RST_VAL;
      mask_q <= REG_RST_VAL;
      stat_q <= REG_RST_VAL;
      irq_q <= 1'b0;
      gpio_out_q <= REG_RST_VAL;
      gpio_oe_q <= REG_RST_VAL;
      rxd_q <= 1'b1;
    end else begin
      if (wr_dir) begin
        dir_q <= i_reg_req.wdata & PIN_VALID_MASK;
      end
      if (wr_out) begin
        out_q <= i_reg_req.wdata & PIN_VALID_MASK;
      end
      if (wr_irq_en) begin
        irq_en_q <= i_reg_req.wdata & IRQ_CAP_MASK;  // see RULE_13, see RULE_14
      end
      if (wr_edge) begin
        edge_q <= i_reg_req.wdata & IRQ_CAP_MASK;
      end
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_d);
      gpio_out_q <= out_q;
      gpio_oe_q <= oe_d;
      rxd_q <= gpio_s[STRAP_PIN];  // see RULE_10
    end
  end

  // Reads answer even during chip reset so firmware tools can poll.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= REG_RST_VAL;
    end else if (i_reg_req.rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= REG_RST_VAL;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_mem_busy = busy_q;
  assign o_mem_rsp = rsp_q;
  assign o_prog_mem.prog_mem_addr = addr_q;
  assign o_prog_mem.prog_mem_wr_n = wr_n_q;
  assign o_prog_mem.prog_mem_rd_n = rd_n_q;
  assign o_prog_mem.prog_mem_ce_n = ce_n_q;
  assign o_prog_mem_data = dout_q;
  assign o_prog_mem_data_oe = doe_q;
  assign o_mem_data_pullup_en = md_pu_q;
  assign o_internal_code_select = code_sel_q;  // see RULE_12
  assign o_gpio_out = gpio_out_q;
  assign o_gpio_oe = gpio_oe_q;
  assign o_strap_pullup_en = pullup_q;  // see RULE_06
  assign o_serial_rxd = rxd_q;

endmodule

`default_nettype wire

/* verilog/pmg_pkg.sv */
package pmg_pkg;

  localparam int PM_ADDR_W = 16;
  localparam int PM_DATA_W = 8;
  localparam int GPIO_W = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 16;
  localparam int CNT_W = 4;

  localparam logic [REG_AW-1:0] REG_DIR_OFF = 8'h00;
  localparam logic [REG_AW-1:0] REG_OUT_OFF = 8'h04;
  localparam logic [REG_AW-1:0] REG_IN_OFF = 8'h08;
  localparam logic [REG_AW-1:0] REG_IRQ_EN_OFF = 8'h0c;
  localparam logic [REG_AW-1:0] REG_EDGE_OFF = 8'h10;
  localparam logic [REG_AW-1:0] REG_STAT_OFF = 8'h14;
  localparam logic [REG_AW-1:0] REG_MASK_OFF = 8'h18;

  localparam logic [GPIO_W-1:0] PIN_VALID_MASK = 16'hfffe;
  localparam logic [GPIO_W-1:0] IRQ_CAP_MASK = 16'h00be;
  localparam logic [GPIO_W-1:0] STRAP_MASK = 16'h0040;
  localparam logic [GPIO_W-1:0] ROM_SEL_MASK = 16'h0001;
  localparam int STRAP_PIN = 6;

  localparam logic [REG_DW-1:0] REG_RST_VAL = 16'h0000;
  localparam logic [PM_DATA_W-1:0] DATA_OE_ALL = 8'hff;
  localparam logic [PM_DATA_W-1:0] DATA_OE_NONE = 8'h00;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int MEM_STROBE_NS = 40;
  localparam int MEM_STROBE_CYC = (MEM_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULLUP_HOLD_NS = 16;
  localparam int PULLUP_HOLD_CYC = (PULLUP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(MEM_STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] PULLUP_LAST = CNT_W'(PULLUP_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } pmg_reg_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PM_ADDR_W-1:0] addr;
    logic [PM_DATA_W-1:0] wdata;
  } pmg_mem_req_t;

  typedef struct packed {
    logic done;
    logic [PM_DATA_W-1:0] rdata;
  } pmg_mem_rsp_t;

  typedef struct packed {
    logic [PM_ADDR_W-1:0] prog_mem_addr;
    logic prog_mem_wr_n;
    logic prog_mem_rd_n;
    logic prog_mem_ce_n;
  } pmg_mem_pins_t;

  typedef enum logic [1:0] {
    MEM_IDLE,
    MEM_STROBE,
    MEM_RECOVER
  } pmg_mem_state_t;

endpackage

/* verilog/pmg_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pmg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* verilog/pmg_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none

module pmg_edge_det #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_level,
  input wire logic [WIDTH-1:0] i_rise_sel,
  input wire logic [WIDTH-1:0] i_en,
  output logic [WIDTH-1:0] o_event
);

  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_q <= '0;
    end else begin
      prev_q <= i_level;
    end
  end

  // Each pin picks its own edge; a disabled pin never raises an event.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      assign o_event[g] = i_en[g] & (i_rise_sel[g] ? (i_level[g] & ~prev_q[g]) : (~i_level[g] & prev_q[g]));
    end
  endgenerate

endmodule

`default_nettype wire

/* verification/pmg_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pmg_top_chk (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_chip_rst_n,
  input wire logic i_suspend,
  input wire pmg_pkg::pmg_reg_req_t i_reg_req,
  input wire logic [pmg_pkg::REG_DW-1:0] o_reg_rdata,
  input wire pmg_pkg::pmg_mem_req_t i_mem_req,
  input wire pmg_pkg::pmg_mem_rsp_t o_mem_rsp,
  input wire pmg_pkg::pmg_mem_pins_t o_prog_mem,
  input wire logic [pmg_pkg::PM_DATA_W-1:0] o_prog_mem_data_oe,
  input wire logic o_internal_code_select,
  input wire logic [pmg_pkg::GPIO_W-1:0] o_gpio_oe,
  input wire logic o_strap_pullup_en
);
  import pmg_pkg::*;
  wire logic rd_n = o_prog_mem.prog_mem_rd_n;
  wire logic wr_n = o_prog_mem.prog_mem_wr_n;
  wire logic ce_n = o_prog_mem.prog_mem_ce_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Ten low cycles; the run is split because repetition counts stay small.
  sequence s_ten_low(s);
    !s [*8] ##1 !s [*2];
  endsequence
  a_srst_idle: assert property (disable iff (1'b0) i_srst |=> ce_n && o_strap_pullup_en)
    else $error("Reset state wrong.");
  a_chip_ce_off: assert property (!i_chip_rst_n [*4] |-> ce_n && o_strap_pullup_en)
    else $error("Chip enable or pull-up wrong in chip reset.");
  a_ce_follow: assert property (i_chip_rst_n [*4] |=> ce_n == $past(i_suspend))
    else $error("Chip enable does not follow suspend.");
  a_pullup_late: assert property ($fell(o_strap_pullup_en) |-> i_chip_rst_n && $past(i_chip_rst_n, 4))
    else $error("Pull-up dropped too early.");
  a_src_hold: assert property ($changed(o_internal_code_select) |-> $past(o_strap_pullup_en))
    else $error("Code source changed outside reset.");
  a_rd_pulse: assert property ($fell(rd_n) |-> s_ten_low(rd_n) ##1 (rd_n && o_mem_rsp.done))
    else $error("Read strobe length wrong.");
  a_wr_pulse: assert property ($fell(wr_n) |-> s_ten_low(wr_n) ##1 (wr_n && o_mem_rsp.done))
    else $error("Write strobe length wrong.");
  a_wr_drive: assert property (!wr_n |-> o_prog_mem_data_oe == DATA_OE_ALL && rd_n)
    else $error("Data not driven during write.");
  a_rd_float: assert property (!rd_n |-> o_prog_mem_data_oe == DATA_OE_NONE && wr_n)
    else $error("Data driven during read.");
  a_addr_take: assert property ($fell(rd_n) || $fell(wr_n) |-> o_prog_mem.prog_mem_addr == $past(i_mem_req.addr))
    else $error("Address differs from request.");
  a_rom_quiet: assert property (o_internal_code_select |-> rd_n && wr_n)
    else $error("Strobe active in internal mode.");
  a_strap_float: assert property (o_strap_pullup_en |-> !o_gpio_oe[STRAP_PIN])
    else $error("Strap pin driven under pull-up.");
  a_rdata_idle: assert property (!$past(i_reg_req.rd) |-> o_reg_rdata == REG_RST_VAL)
    else $error("Read data outside read slot.");
endmodule
bind pmg_top pmg_top_chk u_chk (.i_clk, .i_srst, .i_chip_rst_n, .i_suspend, .i_reg_req, .o_reg_rdata, .i_mem_req,
  .o_mem_rsp, .o_prog_mem, .o_prog_mem_data_oe, .o_internal_code_select, .o_gpio_oe, .o_strap_pullup_en);
`default_nettype wire

/* verification/pmg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmg_mem_model (
  input wire logic i_clk,
  input wire pmg_pkg::pmg_mem_pins_t i_pins,
  input wire logic [pmg_pkg::PM_DATA_W-1:0] i_data,
  input wire logic [pmg_pkg::PM_DATA_W-1:0] i_data_oe,
  output logic [pmg_pkg::PM_DATA_W-1:0] o_data
);
  import pmg_pkg::*;
  logic [PM_DATA_W-1:0] mem [0:65535];
  logic [PM_DATA_W-1:0] last_q = 8'h00;
  wire logic rd_on = !i_pins.prog_mem_rd_n && !i_pins.prog_mem_ce_n;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
  end
  // A released bus toggles every cycle, so a late capture cannot match by luck.
  assign o_data = rd_on ? mem[i_pins.prog_mem_addr] : ~last_q;
  // A plain always block, because the initial block above also writes the array.
  always @(posedge i_clk) begin
    last_q <= o_data;
    if (!i_pins.prog_mem_wr_n && !i_pins.prog_mem_ce_n && i_data_oe == DATA_OE_ALL) begin
      mem[i_pins.prog_mem_addr] <= i_data;
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmg_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_chip_rst_n = 1'b0;
  logic i_suspend = 1'b0;
  pmg_reg_req_t i_reg_req = '0;
  pmg_mem_req_t i_mem_req = '0;
  logic [GPIO_W-1:0] i_gpio = '0;
  logic [PM_DATA_W-1:0] mem_data;
  logic [REG_DW-1:0] o_reg_rdata;
  logic o_irq;
  logic o_mem_busy;
  pmg_mem_rsp_t o_mem_rsp;
  pmg_mem_pins_t o_prog_mem;
  logic [PM_DATA_W-1:0] o_prog_mem_data;
  logic [PM_DATA_W-1:0] o_prog_mem_data_oe;
  logic o_internal_code_select;
  logic o_mem_data_pullup_en;
  logic [GPIO_W-1:0] o_gpio_out;
  logic [GPIO_W-1:0] o_gpio_oe;
  logic o_strap_pullup_en;
  logic o_serial_rxd;
  int bad_count = 0;
  int tests_run = 0;
  logic [REG_DW-1:0] rd_val;
  always #2 i_clk = ~i_clk;
  pmg_top dut (.i_clk, .i_srst, .i_chip_rst_n, .i_suspend, .i_reg_req, .o_reg_rdata, .o_irq, .i_mem_req,
    .o_mem_busy, .o_mem_rsp, .o_prog_mem, .o_prog_mem_data, .o_prog_mem_data_oe, .i_prog_mem_data(mem_data),
    .o_mem_data_pullup_en, .o_internal_code_select, .i_gpio, .o_gpio_out, .o_gpio_oe, .o_strap_pullup_en,
    .o_serial_rxd);
  pmg_mem_model u_mem (.i_clk, .i_pins(o_prog_mem), .i_data(o_prog_mem_data), .i_data_oe(o_prog_mem_data_oe),
    .o_data(mem_data));
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic hang(input string what);
    chk(16'h0000, 16'h0001, what);
    end_sim();
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_reg_req <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_clk);
    i_reg_req <= '0;
    #1;
    d = o_reg_rdata;
  endtask
  task automatic mem_acc(input logic wr, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge i_clk);
    i_mem_req <= '{rd: !wr, wr: wr, addr: a, wdata: wd};
    for (n = 0; n < 20 && o_mem_busy !== 1'b1; n++) tick();
    if (n == 20) hang("access not taken");
    @(posedge i_clk);
    i_mem_req <= '0;
    for (n = 0; n < 20 && o_mem_rsp.done !== 1'b1; n++) tick();
    if (n == 20) hang("access never done");
    rd = o_mem_rsp.rdata;
    tick();
    chk(o_mem_busy, 1'b0, "busy after done");
  endtask
  task automatic t_boot(input logic strap);
    int n;
    @(posedge i_clk);
    i_chip_rst_n <= 1'b0;
    i_gpio <= {9'h000, strap, 6'h00};
    repeat (6) tick();
    chk(o_strap_pullup_en, 1'b1, "pull-up off in reset");
    chk(o_prog_mem.prog_mem_ce_n, 1'b1, "enable on in reset");
    @(posedge i_clk);
    i_chip_rst_n <= 1'b1;
    repeat (3) tick();
    chk(o_strap_pullup_en, 1'b1, "pull-up dropped at edge");
    // Ask for pin six to drive while the pull-up is still on; the drive must wait for its release.
    reg_wr(REG_DIR_OFF, STRAP_MASK);
    tick();
    chk(o_gpio_oe, REG_RST_VAL, "strap driven under pull-up");
    @(posedge i_clk);
    i_gpio <= {9'h000, !strap, 6'h00};
    for (n = 0; n < 20 && o_strap_pullup_en; n++) tick();
    if (n == 20) hang("pull-up stuck");
    repeat (3) tick();
    chk(o_gpio_oe, STRAP_MASK, "strap drive after release");
    chk(o_mem_data_pullup_en, strap, "data bus keepers");
    chk(o_internal_code_select, strap, "code source");
    chk(o_serial_rxd, !strap, "serial input");
    reg_rd(REG_IN_OFF, rd_val);
    chk(rd_val[0], strap, "source status bit");
    chk(rd_val[6], !strap, "pin six input");
    $display("Boot test done, strap %0d", strap);
  endtask
  task automatic t_mem();
    logic [7:0] d;
    mem_acc(1'b1, 16'hffff, 8'h3c, d);
    mem_acc(1'b0, 16'hffff, 8'h00, d);
    chk(d, 8'h3c, "top byte readback");
    mem_acc(1'b0, 16'h0000, 8'h00, d);
    chk(d, 8'h5a, "low byte read");
    @(posedge i_clk);
    i_suspend <= 1'b1;
    i_mem_req <= '{rd: 1'b1, wr: 1'b0, addr: 16'h0001, wdata: 8'h00};
    repeat (4) tick();
    chk(o_prog_mem.prog_mem_ce_n, 1'b1, "enable on in suspend");
    chk(o_mem_busy, 1'b0, "access in suspend");
    @(posedge i_clk);
    i_suspend <= 1'b0;
    i_mem_req <= '0;
    repeat (3) tick();
    chk(o_prog_mem.prog_mem_ce_n, 1'b0, "enable off after suspend");
    $display("Memory test done");
  endtask
  task automatic t_gpio();
    reg_wr(REG_DIR_OFF, 16'hffff);
    reg_wr(REG_OUT_OFF, 16'ha5a5);
    repeat (2) tick();
    chk(o_gpio_oe, PIN_VALID_MASK, "drive enables");
    chk(o_gpio_out, 16'ha5a4, "pin outputs");
    reg_rd(REG_DIR_OFF, rd_val);
    chk(rd_val, PIN_VALID_MASK, "direction readback");
    reg_rd(REG_OUT_OFF, rd_val);
    chk(rd_val, 16'ha5a4, "output readback");
    reg_wr(REG_DIR_OFF, 16'h0000);
    @(posedge i_clk);
    i_gpio <= 16'h9a7f;
    repeat (4) tick();
    reg_rd(REG_IN_OFF, rd_val);
    chk(rd_val, 16'h9a7e, "pin inputs");
    reg_rd(8'h1c, rd_val);
    chk(rd_val, 16'h0000, "unmapped read");
    $display("Pin test done");
  endtask
  task automatic t_irq();
    reg_wr(REG_IRQ_EN_OFF, 16'hffff);
    reg_wr(REG_EDGE_OFF, 16'hffff);
    reg_wr(REG_MASK_OFF, 16'hffff);
    reg_rd(REG_IRQ_EN_OFF, rd_val);
    chk(rd_val, IRQ_CAP_MASK, "enable readback");
    reg_rd(REG_EDGE_OFF, rd_val);
    chk(rd_val, IRQ_CAP_MASK, "edge readback");
    reg_rd(REG_MASK_OFF, rd_val);
    chk(rd_val, IRQ_CAP_MASK, "mask readback");
    @(posedge i_clk);
    i_gpio <= 16'h0000;
    repeat (4) tick();
    reg_rd(REG_STAT_OFF, rd_val);
    @(posedge i_clk);
    i_gpio <= 16'hfffe;
    repeat (4) tick();
    chk(o_irq, 1'b1, "no interrupt");
    reg_rd(REG_STAT_OFF, rd_val);
    chk(rd_val, IRQ_CAP_MASK, "rising events");
    tick();
    chk(o_irq, 1'b0, "interrupt stuck");
    reg_wr(REG_MASK_OFF, 16'h0000);
    reg_wr(REG_EDGE_OFF, 16'h0000);
    @(posedge i_clk);
    i_gpio <= 16'h0000;
    repeat (4) tick();
    chk(o_irq, 1'b0, "masked interrupt");
    reg_rd(REG_STAT_OFF, rd_val);
    chk(rd_val, IRQ_CAP_MASK, "falling events");
    $display("Interrupt test done");
  endtask
  task automatic t_rom();
    @(posedge i_clk);
    i_mem_req <= '{rd: 1'b1, wr: 1'b0, addr: 16'h0010, wdata: 8'h00};
    repeat (4) tick();
    chk(o_mem_busy, 1'b0, "access from internal mode");
    chk(o_prog_mem.prog_mem_rd_n, 1'b1, "strobe in internal mode");
    @(posedge i_clk);
    i_mem_req <= '0;
    $display("Internal mode test done");
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    tick();
    chk(o_prog_mem.prog_mem_ce_n, 1'b1, "enable after reset");
    t_boot(1'b0);
    t_mem();
    t_gpio();
    t_irq();
    t_boot(1'b1);
    t_rom();
    end_sim();
  end
endmodule
`default_nettype wire
